// >>> adcs_regs.svh
// Register offsets, field positions and reset values of the converter selection block.
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

`define ADCS_ADDR_W            8
`define ADCS_OFF_MUX_SELECT    8'h7c
`define ADCS_OFF_RESULT_LOW    8'h70
`define ADCS_OFF_RESULT_HIGH   8'h74
`define ADCS_OFF_IRQ_STATUS    8'h60
`define ADCS_OFF_IRQ_MASK      8'h64
`define ADCS_OFF_CONTROL       8'h68

`define ADCS_MUX_REF_HI        7
`define ADCS_MUX_REF_LO        6
`define ADCS_MUX_ALIGN_BIT     5
`define ADCS_MUX_CHAN_HI       4
`define ADCS_MUX_CHAN_LO       0

`define ADCS_STAT_DONE_BIT     0
`define ADCS_CTRL_START_BIT    0
`define ADCS_CTRL_BUSY_BIT     1

`define ADCS_RST_MUX_SELECT    8'h00
`define ADCS_RST_RESULT        10'h000
`define ADCS_RST_IRQ_MASK      1'b0

`define ADCS_DIFF_SIGN_FLIP    10'h200
`define ADCS_RESP_OKAY         2'b00
`define ADCS_RESP_SLVERR       2'b10

`endif

// >>> adcs_pkg.sv
// Types shared by the converter selection block and its channel decoder.
`default_nettype none
package adcs_pkg;

    typedef enum logic [1:0] {
        ADCS_REF_PIN,
        ADCS_REF_SUPPLY,
        ADCS_REF_1V1,
        ADCS_REF_2V56
    } adcs_ref_t;

    typedef enum logic [1:0] {
        ADCS_GAIN_1X,
        ADCS_GAIN_10X,
        ADCS_GAIN_200X
    } adcs_gain_t;

    typedef struct packed {
        logic       differential;
        logic       bandgap;
        logic       ground;
        logic [2:0] pos_input;
        logic [2:0] neg_input;
        adcs_gain_t gain;
    } adcs_route_t;

endpackage
`default_nettype wire

// >>> adcs_chan_decode.sv
// Decoder from the 5-bit channel and gain field to an analog input route.
`default_nettype none
`timescale 1ns/1ns
module adcs_chan_decode (
    input  wire logic [4:0]          channel_gain_field,
    output adcs_pkg::adcs_route_t    route
);
    always_comb begin
        route              = '0;
        route.gain         = adcs_pkg::ADCS_GAIN_1X;
        route.pos_input    = channel_gain_field[2:0];
        unique case (channel_gain_field[4:3])
            2'b00: begin
                route.differential = 1'b0;
            end
            2'b01: begin
                route.differential = 1'b1;
                route.pos_input    = {1'b0, channel_gain_field[2], channel_gain_field[0]};
                route.neg_input    = channel_gain_field[2] ? 3'h2 : 3'h0;
                route.gain         = channel_gain_field[1] ? adcs_pkg::ADCS_GAIN_200X
                                                           : adcs_pkg::ADCS_GAIN_10X;
            end
            2'b10: begin
                route.differential = 1'b1;
                route.neg_input    = 3'h1;
            end
            2'b11: begin
                if (channel_gain_field[2:1] == 2'b11) begin
                    route.bandgap   = ~channel_gain_field[0];
                    route.ground    = channel_gain_field[0];
                    route.pos_input = 3'h0;
                end else begin
                    route.differential = 1'b1;
                    route.neg_input    = 3'h2;
                end
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> adcs_top.sv
// Converter selection, result formatting and AXI4-Lite register slave.
//
// Functional notes
// - Single-ended result is unsigned 10 bits, 0x000 ground, 0x3ff reference less one step.
// - Single-ended code equals input voltage times 1024 over the reference.
// - Differential code equals difference times gain times 512 over the reference.
// - Differential results are two's complement, 0x200 for -512 to 0x1ff for +511.
// - Top bit of a differential result is its sign, one meaning negative.
// - New result appears in the low and high bytes when the done flag rises.
// - Reference field 00 pin, 01 analog supply, 10 internal 1.1V, 11 internal 2.56V.
// - Reference or channel changes mid-conversion apply only once that conversion is done.
// - Alignment bit one left-aligns the result; zero right-aligns it.
// - Alignment changes reformat the visible result at once, even mid-conversion.
// - Channel codes 0 to 7 single-ended inputs; 11110 bandgap; 11111 ground.
// - Codes 01000 to 01111 are differential pairs at gain 10x or 200x.
// - Codes 10000 to 11101 are unity gain pairs against input 1 or input 2.
// - After a low byte read, result updates wait until the high byte is read; the code drops a result finishing in that window.
// - Left: high byte holds bits 9:2, low 7:6 bits 1:0; right: high 1:0 bits 9:8.
//
// Our own choice: the AXI4-Lite register port.
`include "adcs_regs.svh"
`default_nettype none
`timescale 1ns/1ns
module adcs_top #(
    parameter int RESULT_W = 10
) (
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic                      irq,
    output logic                      conv_start,
    output logic                      conv_busy,
    input  wire logic                 conv_done,
    input  wire logic [9:0]           conv_code,
    output adcs_pkg::adcs_ref_t       reference_source_field,
    output adcs_pkg::adcs_route_t     input_route
);

    // The formatting below is written for a 10-bit code only.
    if (RESULT_W != 10) begin : g_bad_width
        $error("adcs_top supports RESULT_W of 10 only");
    end

    // Register state.
    logic [7:0]             mux_select_ff;
    logic [7:0]             nxt_mux_select;
    logic [7:0]             shadow_ff;
    logic [7:0]             nxt_shadow;
    logic [9:0]             result_ff;
    logic [9:0]             nxt_result;
    logic                   lock_ff;
    logic                   nxt_lock;
    logic                   done_flag_ff;
    logic                   nxt_done_flag;
    logic                   mask_ff;
    logic                   nxt_mask;
    logic                   busy_ff;
    logic                   nxt_busy;
    logic                   start_ff;

    // Write channel state.
    logic                   aw_held_ff;
    logic [7:0]             aw_addr_ff;
    logic                   w_held_ff;
    logic [31:0]            w_data_ff;
    logic [3:0]             w_strb_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;

    // Read channel state.
    logic                   rvalid_ff;
    logic [31:0]            rdata_ff;
    logic [1:0]             rresp_ff;

    // Write decode.
    wire logic              aw_take   = s_axi_awvalid & s_axi_awready;
    wire logic              w_take    = s_axi_wvalid & s_axi_wready;
    wire logic              aw_have   = aw_held_ff | aw_take;
    wire logic              w_have    = w_held_ff | w_take;
    wire logic              wr_fire   = aw_have & w_have;
    wire logic [7:0]        wr_addr   = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    wire logic [31:0]       wr_data   = w_held_ff ? w_data_ff : s_axi_wdata;
    wire logic [3:0]        wr_strb   = w_held_ff ? w_strb_ff : s_axi_wstrb;
    wire logic              wr_lane0  = wr_fire & wr_strb[0];
    wire logic              wr_mux    = wr_addr == `ADCS_OFF_MUX_SELECT;
    wire logic              wr_stat   = wr_addr == `ADCS_OFF_IRQ_STATUS;
    wire logic              wr_mask   = wr_addr == `ADCS_OFF_IRQ_MASK;
    wire logic              wr_ctrl   = wr_addr == `ADCS_OFF_CONTROL;
    wire logic              wr_lo     = wr_addr == `ADCS_OFF_RESULT_LOW;
    wire logic              wr_hi     = wr_addr == `ADCS_OFF_RESULT_HIGH;
    wire logic              wr_mapped = wr_mux | wr_stat | wr_mask | wr_ctrl | wr_lo | wr_hi;

    // Read decode; the result byte reads carry the lock side effect.
    wire logic              ar_take   = s_axi_arvalid & s_axi_arready;
    wire logic              rd_mux    = s_axi_araddr == `ADCS_OFF_MUX_SELECT;
    wire logic              rd_stat   = s_axi_araddr == `ADCS_OFF_IRQ_STATUS;
    wire logic              rd_mask   = s_axi_araddr == `ADCS_OFF_IRQ_MASK;
    wire logic              rd_ctrl   = s_axi_araddr == `ADCS_OFF_CONTROL;
    wire logic              rd_lo     = s_axi_araddr == `ADCS_OFF_RESULT_LOW;
    wire logic              rd_hi     = s_axi_araddr == `ADCS_OFF_RESULT_HIGH;
    wire logic              rd_mapped = rd_mux | rd_stat | rd_mask | rd_ctrl | rd_lo | rd_hi;
    wire logic              lo_read   = ar_take & rd_lo;
    wire logic              hi_read   = ar_take & rd_hi;

    // Live alignment bit and shadowed reference and channel fields of the selection register.
    wire logic              align_left = mux_select_ff[`ADCS_MUX_ALIGN_BIT];
    wire logic [1:0]        shadow_ref = shadow_ff[`ADCS_MUX_REF_HI:`ADCS_MUX_REF_LO];
    wire logic [4:0]        shadow_chan = shadow_ff[`ADCS_MUX_CHAN_HI:`ADCS_MUX_CHAN_LO];

    // Conversion control.
    wire logic              start_req = wr_lane0 & wr_ctrl & wr_data[`ADCS_CTRL_START_BIT];
    wire logic              start_ok  = start_req & ~busy_ff;
    wire logic              finish    = busy_ff & conv_done;

    // Formatting of the finished code.
    adcs_pkg::adcs_route_t  route;
    wire logic [9:0]        diff_code = conv_code ^ `ADCS_DIFF_SIGN_FLIP;
    wire logic [9:0]        fmt_code  = route.differential ? diff_code
                                                           : conv_code;

    // Visible bytes are formed from the stored result and the live alignment bit.
    wire logic [7:0]        low_left  = {result_ff[1:0], 6'h00};
    wire logic [7:0]        high_left = result_ff[9:2];
    wire logic [7:0]        low_right = result_ff[7:0];
    wire logic [7:0]        high_right = {6'h00, result_ff[9:8]};
    wire logic [7:0]        low_view  = align_left ? low_left : low_right;
    wire logic [7:0]        high_view = align_left ? high_left : high_right;

    // Read data selection.
    wire logic [7:0]        rd_byte =
        rd_mux  ? mux_select_ff :
        rd_lo   ? low_view :
        rd_hi   ? high_view :
        rd_stat ? {7'h00, done_flag_ff} :
        rd_mask ? {7'h00, mask_ff} :
        rd_ctrl ? {6'h00, busy_ff, 1'b0} :
        8'h00;

    adcs_chan_decode u_chan_decode (
        .channel_gain_field (shadow_chan),
        .route              (route)
    );

    // Next values of the register file.
    always_comb begin
        nxt_mux_select = mux_select_ff;
        if (wr_lane0 & wr_mux) begin
            nxt_mux_select = wr_data[7:0];
        end
    end

    always_comb begin
        nxt_shadow = shadow_ff;
        if (!busy_ff) begin
            nxt_shadow = mux_select_ff;
        end
    end

    always_comb begin
        nxt_busy = busy_ff;
        if (start_ok) begin
            nxt_busy = 1'b1;
        end else if (finish) begin
            nxt_busy = 1'b0;
        end
    end

    always_comb begin
        nxt_lock = lock_ff;
        if (lo_read) begin
            nxt_lock = 1'b1;
        end else if (hi_read) begin
            nxt_lock = 1'b0;
        end
    end

    always_comb begin
        nxt_result = result_ff;
        if (finish && !lock_ff) begin
            nxt_result = fmt_code;
        end
    end

    // A completion in the same cycle as a write-one clear keeps the flag set.
    always_comb begin
        nxt_done_flag = done_flag_ff;
        if (wr_lane0 & wr_stat & wr_data[`ADCS_STAT_DONE_BIT]) begin
            nxt_done_flag = 1'b0;
        end
        if (finish) begin
            nxt_done_flag = 1'b1;
        end
    end

    always_comb begin
        nxt_mask = mask_ff;
        if (wr_lane0 & wr_mask) begin
            nxt_mask = wr_data[0];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mux_select_ff <= `ADCS_RST_MUX_SELECT;
            shadow_ff     <= `ADCS_RST_MUX_SELECT;
            result_ff     <= `ADCS_RST_RESULT;
            lock_ff       <= 1'b0;
            done_flag_ff  <= 1'b0;
            mask_ff       <= `ADCS_RST_IRQ_MASK;
            busy_ff       <= 1'b0;
            start_ff      <= 1'b0;
        end else begin
            mux_select_ff <= nxt_mux_select;
            shadow_ff     <= nxt_shadow;
            result_ff     <= nxt_result;
            lock_ff       <= nxt_lock;
            done_flag_ff  <= nxt_done_flag;
            mask_ff       <= nxt_mask;
            busy_ff       <= nxt_busy;
            start_ff      <= start_ok;
        end
    end

    // Write address and data are held separately until both have arrived.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end else if (aw_take) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end else if (w_take) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `ADCS_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_mapped ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `ADCS_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h00_0000, rd_byte};
            rresp_ff  <= rd_mapped ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Bus handshakes.
    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Interrupt and converter side.
    assign irq        = done_flag_ff & mask_ff;
    assign conv_start = start_ff;
    assign conv_busy  = busy_ff;

    always_comb begin
        unique case (shadow_ref)
            2'b00: reference_source_field = adcs_pkg::ADCS_REF_PIN;
            2'b01: reference_source_field = adcs_pkg::ADCS_REF_SUPPLY;
            2'b10: reference_source_field = adcs_pkg::ADCS_REF_1V1;
            2'b11: reference_source_field = adcs_pkg::ADCS_REF_2V56;
        endcase
    end

    assign input_route = route;

    // Protection bits carry no meaning for this slave.
    wire logic [5:0] unused_prot = {s_axi_awprot, s_axi_arprot};

endmodule
`default_nettype wire

// >>> adcs_top_asserts.sv
// Port-level concurrent checks for the converter selection block.
`default_nettype none
`timescale 1ns/1ns
module adcs_top_asserts (
    input wire logic                  clock,
    input wire logic                  reset_n,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  irq,
    input wire logic                  conv_start,
    input wire logic                  conv_busy,
    input wire logic                  conv_done,
    input wire adcs_pkg::adcs_ref_t   reference_source_field,
    input wire adcs_pkg::adcs_route_t input_route
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    chk_shadow_held: assert property (conv_busy && $past(conv_busy) |->
        $stable(input_route) && $stable(reference_source_field)) else $error("route moved while busy");
    chk_start_busy: assert property (conv_start |-> ##[0:1] conv_busy)
        else $error("start without busy");
    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    chk_busy_done: assert property (conv_busy && conv_done |=> !conv_busy)
        else $error("busy stayed after done");
    chk_busy_stays: assert property (conv_busy && !conv_done |=> conv_busy)
        else $error("busy fell without done");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_gain_diff: assert property (input_route.gain != adcs_pkg::ADCS_GAIN_1X |->
        input_route.differential) else $error("gain on single input");
    chk_fixed_source: assert property (input_route.bandgap || input_route.ground |->
        !input_route.differential && input_route.pos_input == 3'h0) else $error("fixed source bad");

    cover property (conv_busy && conv_done);
    cover property ($rose(irq));
    cover property (input_route.gain == adcs_pkg::ADCS_GAIN_200X);
endmodule

bind adcs_top adcs_top_asserts u_adcs_top_asserts (.clock, .reset_n, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq, .conv_start, .conv_busy,
    .conv_done, .reference_source_field, .input_route);
`default_nettype wire

// >>> adcs_conv_model.sv
// Behavioural converter core returning a preset raw code after a set latency.
`default_nettype none
`timescale 1ns/1ns
module adcs_conv_model (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       conv_start,
    input  wire logic [9:0] raw_code,
    input  wire logic [7:0] latency,
    output logic            conv_done,
    output logic [9:0]      conv_code
);
    logic [7:0] count_ff;
    logic       run_ff;

    // Outside the done pulse the code toggles so a stale capture cannot match.
    always_ff @(posedge clock) begin
        conv_done <= 1'b0;
        conv_code <= ~conv_code;
        if (!reset_n) begin
            run_ff    <= 1'b0;
            count_ff  <= 8'h00;
            conv_code <= 10'h155;
        end else if (conv_start) begin
            run_ff   <= 1'b1;
            count_ff <= latency;
        end else if (run_ff && count_ff == 8'h00) begin
            run_ff    <= 1'b0;
            conv_done <= 1'b1;
            conv_code <= raw_code;
        end else if (run_ff) begin
            count_ff <= count_ff - 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench: register access, conversions, result formatting, route decode.
`include "adcs_regs.svh"
`default_nettype none
`timescale 1ns/1ns
module testbench;
    logic                  clock, reset_n, irq, conv_start, conv_busy, conv_done;
    logic [7:0]            s_axi_awaddr, s_axi_araddr, latency;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                  s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0]           s_axi_wdata, s_axi_rdata, d;
    logic [1:0]            s_axi_bresp, s_axi_rresp, last_resp;
    logic [9:0]            conv_code, raw_code;
    adcs_pkg::adcs_ref_t   reference_source_field;
    adcs_pkg::adcs_route_t input_route, er;
    int                    errors, n_compared, i;
    wire logic [3:0]       route_sel = {input_route.differential, input_route.pos_input};

    adcs_top u_adcs_top (.clock, .reset_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready(1'b1), .irq, .conv_start, .conv_busy, .conv_done, .conv_code,
        .reference_source_field, .input_route);
    adcs_conv_model u_adcs_conv_model (.clock, .reset_n, .conv_start, .raw_code, .latency,
        .conv_done, .conv_code);

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        last_resp = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        last_resp = s_axi_rresp;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic wait_done;
        repeat (3) @(posedge clock);
        while (conv_busy !== 1'b0) @(posedge clock);
    endtask

    function automatic adcs_pkg::adcs_route_t exp_route(input logic [4:0] c);
        adcs_pkg::adcs_route_t r;
        r = '0;
        r.bandgap = (c == 5'h1e);
        r.ground = (c == 5'h1f);
        r.differential = (c >= 5'h08) && (c <= 5'h1d);
        r.pos_input = (c >= 5'h1e) ? 3'h0 : c[2:0];
        if (c[4:3] == 2'b01) begin
            r.pos_input = {1'b0, c[2], c[0]};
            r.neg_input = {1'b0, c[2], 1'b0};
            r.gain = c[1] ? adcs_pkg::ADCS_GAIN_200X : adcs_pkg::ADCS_GAIN_10X;
        end
        if (c[4:3] == 2'b10) r.neg_input = 3'h1;
        if (c[4:3] == 2'b11 && c < 5'h1e) r.neg_input = 3'h2;
        return r;
    endfunction

    task automatic final_report;
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        final_report();
    end

    initial begin
        reset_n = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
        raw_code = 10'h000;
        latency = 8'd40;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        rd(`ADCS_OFF_MUX_SELECT); chk("mux reset", 32'h0, d);
        rd(`ADCS_OFF_RESULT_HIGH); chk("high reset", 32'h0, d);
        rd(8'h40); chk("unmapped resp", 32'(`ADCS_RESP_SLVERR), 32'(last_resp));
        chk("unmapped data", 32'h0, d);
        wr(8'h40, 32'h0); chk("unmapped wr resp", 32'(`ADCS_RESP_SLVERR), 32'(last_resp));
        wr(`ADCS_OFF_MUX_SELECT, 32'hed);
        chk("write resp", 32'(`ADCS_RESP_OKAY), 32'(last_resp));
        rd(`ADCS_OFF_MUX_SELECT); chk("mux readback", 32'hed, d);
        chk("reference", 32'(adcs_pkg::ADCS_REF_2V56), 32'(reference_source_field));
        wr(`ADCS_OFF_IRQ_MASK, 32'h1);
        raw_code <= 10'h070;
        wr(`ADCS_OFF_CONTROL, 32'h1);
        wr(`ADCS_OFF_MUX_SELECT, 32'ha2);
        chk("ref held", 32'(adcs_pkg::ADCS_REF_2V56), 32'(reference_source_field));
        chk("route held", 32'h0b, 32'(route_sel));
        rd(`ADCS_OFF_CONTROL); chk("busy bit", 32'h2, d);
        wait_done();
        chk("irq done", 32'h1, 32'(irq));
        rd(`ADCS_OFF_RESULT_LOW); chk("low left", 32'h00, d);
        rd(`ADCS_OFF_RESULT_HIGH); chk("high left", 32'h9c, d);
        chk("ref after", 32'(adcs_pkg::ADCS_REF_1V1), 32'(reference_source_field));
        chk("route after", 32'h02, 32'(route_sel));
        wr(`ADCS_OFF_MUX_SELECT, 32'h42);
        rd(`ADCS_OFF_RESULT_LOW); chk("low right", 32'h70, d);
        chk("ref supply", 32'(adcs_pkg::ADCS_REF_SUPPLY), 32'(reference_source_field));
        rd(`ADCS_OFF_RESULT_HIGH); chk("high right", 32'h02, d);
        wr(`ADCS_OFF_IRQ_STATUS, 32'h1); chk("irq cleared", 32'h0, 32'(irq));
        wr(`ADCS_OFF_IRQ_MASK, 32'h0);
        rd(`ADCS_OFF_RESULT_LOW);
        raw_code <= 10'h3ff;
        wr(`ADCS_OFF_CONTROL, 32'h1);
        wait_done();
        chk("irq masked", 32'h0, 32'(irq));
        rd(`ADCS_OFF_IRQ_STATUS); chk("flag while masked", 32'h1, d);
        rd(`ADCS_OFF_RESULT_HIGH); chk("high locked", 32'h02, d);
        wr(`ADCS_OFF_CONTROL, 32'h1);
        wr(`ADCS_OFF_MUX_SELECT, 32'h62);
        rd(`ADCS_OFF_RESULT_HIGH); chk("high realigned", 32'h9c, d);
        wait_done();
        rd(`ADCS_OFF_RESULT_LOW); chk("low full", 32'hc0, d);
        rd(`ADCS_OFF_RESULT_HIGH); chk("high full", 32'hff, d);
        for (i = 0; i < 32; i++) begin
            wr(`ADCS_OFF_MUX_SELECT, 32'(i));
            @(posedge clock);
            er = exp_route(i[4:0]);
            chk("route", 32'(er), 32'(input_route));
            chk("ref pin", 32'(adcs_pkg::ADCS_REF_PIN), 32'(reference_source_field));
        end
        final_report();
    end
endmodule
`default_nettype wire
